// ---- include/eeprom_pkg.sv ----
/*
 * Shared constants for the two-wire EEPROM write path: byte kinds, page
 * geometry, write-cycle timing and the write-path state encoding.
 * Assumes a 20 MHz core clock; nothing else is needed from the surroundings.
 */
`default_nettype none

package eeprom_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int WR_TIME_MS = 5;
    // The longest write time rounds down to whole core cycles.
    localparam int WR_CYCLES_DFLT = WR_TIME_MS * (CLK_HZ / 1000);

    // ************************************************************
    // Geometry and byte framing
    // ************************************************************
    localparam int ADDR_W = 16;
    localparam int PAGE_AW = 7;
    localparam int PAGE_N = 128;
    localparam logic [7:0] PAGE_BYTES = 8'h80;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [1:0] KIND_DEV = 2'h0;
    localparam logic [1:0] KIND_AHI = 2'h1;
    localparam logic [1:0] KIND_ALO = 2'h2;
    localparam logic [1:0] KIND_DATA = 2'h3;
    localparam logic IDLE_RST = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_PROG = 2'b11
    } wr_state_t;

endpackage

`default_nettype wire

// ---- design/bit_sync.sv ----
/*
 * Two-flip-flop level synchroniser, one lane per bit.
 * Assumes each input is a level that stays put for several destination clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // The first stage feeds only the second stage.
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;

endmodule

`default_nettype wire

// ---- design/link_engine.sv ----
/*
 * Serial-clock domain of the write path: bit sampling, start detection,
 * address matching, per-byte acknowledge and hand-off of received bytes.
 * Assumes the serial clock is a clock port, and that the core holds bus_idle
 * high from each stop until it has seen the following start.
 */
`timescale 1ns/10ps
`default_nettype none

module link_engine #(
    // Device-type pattern; the value is arbitrary.
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    input wire logic scl_clk,
    input wire logic nrst,
    input wire logic sda_in,
    input wire logic [2:0] dev_sel,
    input wire logic write_busy,
    input wire logic bus_idle,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output logic [1:0] rx_kind,
    output logic rx_tgl
);

    logic [4:0] sync_v;
    logic rst_n;
    logic busy_s;
    logic [2:0] sel_s;
    logic first;
    logic match;
    logic [7:0] word;
    logic smp_q, smp_d, live_q, live_d, rd_q, rd_d, ack_q, ack_d, tgl_q, tgl_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d, byte_q, byte_d;
    logic [1:0] num_q, num_d, kind_q, kind_d;
    logic start_q, start_d, oe_q, oe_d, idle_m_q, idle_m_d;

    bit_sync #(.WIDTH(5)) u_sync (
        .clk(scl_clk),
        .async_in({nrst, write_busy, dev_sel}),
        .sync_out(sync_v)
    );

    assign rst_n = sync_v[4];
    assign busy_s = sync_v[3];
    assign sel_s = sync_v[2:0];

    // ************************************************************
    // Rising-edge side
    // ************************************************************
    always_comb
    begin
        // After a stop the clock stands high, so the start's falling edge is the only
        // edge that sees the idle flag before the first bit. A second stage would come
        // a bit too late, so half a serial period of settling is traded for it.
        first = start_q | idle_m_q;
        word = {shift_q[6:0], sda_in};
        match = word[7:4] == DEV_TYPE && word[3:1] == sel_s && !busy_s;
        smp_d = sda_in;
        cnt_d = cnt_q;
        shift_d = shift_q;
        num_d = num_q;
        live_d = live_q;
        rd_d = rd_q;
        ack_d = ack_q;
        byte_d = byte_q;
        kind_d = kind_q;
        tgl_d = tgl_q;
        if (first)
        begin
            cnt_d = 4'h1;
            shift_d = {7'h00, sda_in};
            num_d = eeprom_pkg::KIND_DEV;
            live_d = 1'b1;
            rd_d = 1'b0;
            ack_d = 1'b0;
        end
        else if (cnt_q == eeprom_pkg::BIT_ACK)
        begin
            cnt_d = 4'h0;
            ack_d = 1'b0;
            if (!ack_q)
            begin
                live_d = 1'b0;
            end
            if (ack_q && num_q != eeprom_pkg::KIND_DATA)
            begin
                num_d = num_q + 2'h1;
            end
        end
        else
        begin
            cnt_d = cnt_q + 4'h1;
            shift_d = word;
            if (cnt_q == eeprom_pkg::BIT_LAST)
            begin
                if (num_q == eeprom_pkg::KIND_DEV)
                begin
                    ack_d = live_q & match;
                    rd_d = word[0];
                end
                else
                begin
                    ack_d = live_q & !rd_q;
                    if (live_q && !rd_q)
                    begin
                        byte_d = word;
                        kind_d = num_q;
                        tgl_d = ~tgl_q;
                    end
                end
            end
        end
        if (!rst_n)
        begin
            smp_d = 1'b1;
            cnt_d = 4'h0;
            shift_d = 8'h00;
            num_d = eeprom_pkg::KIND_DEV;
            live_d = 1'b0;
            rd_d = 1'b0;
            ack_d = 1'b0;
            byte_d = 8'h00;
            kind_d = eeprom_pkg::KIND_DEV;
            tgl_d = 1'b0;
        end
    end

    always_ff @(posedge scl_clk)
    begin
        smp_q <= smp_d;
        cnt_q <= cnt_d;
        shift_q <= shift_d;
        num_q <= num_d;
        live_q <= live_d;
        rd_q <= rd_d;
        ack_q <= ack_d;
        byte_q <= byte_d;
        kind_q <= kind_d;
        tgl_q <= tgl_d;
    end

    // ************************************************************
    // Falling-edge side
    // ************************************************************
    // A data line that differs between the rising and falling edge moved while
    // the clock was high; a high-to-low move is a start.
    always_comb
    begin
        start_d = smp_q & ~sda_in;
        oe_d = (cnt_q == eeprom_pkg::BIT_ACK) & ack_q;
        idle_m_d = bus_idle;
        if (!rst_n)
        begin
            start_d = 1'b0;
            oe_d = 1'b0;
            idle_m_d = eeprom_pkg::IDLE_RST;
        end
    end

    always_ff @(negedge scl_clk)
    begin
        start_q <= start_d;
        oe_q <= oe_d;
        idle_m_q <= idle_m_d;
    end

    assign sda_oe = oe_q;
    assign rx_byte = byte_q;
    assign rx_kind = kind_q;
    assign rx_tgl = tgl_q;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_dev_match;
        @(posedge scl_clk) disable iff (!rst_n)
        (ack_q && cnt_q == eeprom_pkg::BIT_ACK && num_q == eeprom_pkg::KIND_DEV)
            |-> shift_q[7:4] == DEV_TYPE && shift_q[3:1] == $past(sel_s);
    endproperty
    a_dev_match: assert property (p_dev_match) else $error("ack on foreign address");

    property p_busy_nak;
        @(posedge scl_clk) disable iff (!rst_n)
        (!first && busy_s && cnt_q == eeprom_pkg::BIT_LAST && num_q == eeprom_pkg::KIND_DEV)
            |=> !sda_oe [*2];
    endproperty
    a_busy_nak: assert property (p_busy_nak) else $error("ack while writing");

    property p_byte_out;
        @(posedge scl_clk) disable iff (!rst_n)
        $changed(tgl_q) |-> ack_q && cnt_q == eeprom_pkg::BIT_ACK
            && kind_q != eeprom_pkg::KIND_DEV && !rd_q;
    endproperty
    a_byte_out: assert property (p_byte_out) else $error("byte handed off wrongly");

endmodule

`default_nettype wire

// ---- design/eeprom_write_path.sv ----
/*
 * Two-wire target write path of a serial EEPROM: start/stop tracking,
 * word-address counter, page buffer, self-timed write cycle and write
 * protection. The link engine runs on the serial clock itself.
 * Assumes an external open-drain pull-up on the data line and an array port
 * that accepts one byte per core cycle while mem_we is high.
 */
`timescale 1ns/10ps
`default_nettype none

module eeprom_write_path #(
    // Device-type pattern; the value is arbitrary.
    parameter logic [3:0] DEV_TYPE = 4'h5,
    parameter int WR_CYCLES = eeprom_pkg::WR_CYCLES_DFLT
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic serial_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic device_select_bit2,
    input wire logic device_select_bit1,
    input wire logic device_select_bit0,
    input wire logic write_protect,
    output logic write_busy,
    output logic standby,
    output logic [15:0] word_addr,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata
);

    localparam logic [16:0] WR_LAST = 17'(WR_CYCLES - 1);

    logic [7:0] rx_byte;
    logic [1:0] rx_kind;
    logic rx_tgl;
    logic [3:0] sync_v;
    logic scl_s, sda_s, wp_s, tgl_s;
    logic scl_p_q, scl_p_d, sda_p_q, sda_p_d, tgl_p_q, tgl_p_d;
    logic start_ev, stop_ev, byte_ev, wr_hit, clr;
    logic idle_q, idle_d;
    eeprom_pkg::wr_state_t state_q, state_d;
    logic [15:0] addr_q, addr_d;
    logic [16:0] timer_q, timer_d;
    logic [7:0] idx_q, idx_d;
    logic we_q, we_d;
    logic [15:0] maddr_q, maddr_d;
    logic [7:0] mdata_q, mdata_d;
    logic [eeprom_pkg::PAGE_N-1:0] vld_q;
    logic [7:0] pbuf_q [eeprom_pkg::PAGE_N];

    // ************************************************************
    // Link side
    // ************************************************************
    link_engine #(.DEV_TYPE(DEV_TYPE)) u_link (
        .scl_clk(serial_clk),
        .nrst(nrst),
        .sda_in(sda_in),
        .dev_sel({device_select_bit2, device_select_bit1, device_select_bit0}),
        .write_busy(write_busy),
        .bus_idle(idle_q),
        .sda_oe(sda_oe),
        .rx_byte(rx_byte),
        .rx_kind(rx_kind),
        .rx_tgl(rx_tgl)
    );

    // Open drain: the line is only ever pulled low.
    assign sda_out = 1'b0;

    bit_sync #(.WIDTH(4)) u_sync (
        .clk(core_clk),
        .async_in({serial_clk, sda_in, write_protect, rx_tgl}),
        .sync_out(sync_v)
    );

    assign scl_s = sync_v[3];
    assign sda_s = sync_v[2];
    assign wp_s = sync_v[1];
    assign tgl_s = sync_v[0];

    // ************************************************************
    // Bus conditions
    // ************************************************************
    always_comb
    begin
        start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
        stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
        // Bytes are stable in the link registers long before the toggle
        // arrives here, so they are read without a second synchroniser.
        byte_ev = tgl_s ^ tgl_p_q;
        wr_hit = byte_ev && rx_kind == eeprom_pkg::KIND_DATA
            && state_q != eeprom_pkg::ST_PROG;
        scl_p_d = scl_s;
        sda_p_d = sda_s;
        tgl_p_d = tgl_s;
        idle_d = idle_q;
        if (start_ev)
        begin
            idle_d = 1'b0;
        end
        if (stop_ev)
        begin
            idle_d = 1'b1;
        end
        if (!nrst)
        begin
            scl_p_d = 1'b1;
            sda_p_d = 1'b1;
            tgl_p_d = 1'b0;
            idle_d = eeprom_pkg::IDLE_RST;
        end
    end

    always_ff @(posedge core_clk)
    begin
        scl_p_q <= scl_p_d;
        sda_p_q <= sda_p_d;
        tgl_p_q <= tgl_p_d;
        idle_q <= idle_d;
    end

    // ************************************************************
    // Write sequencing
    // ************************************************************
    always_comb
    begin
        state_d = state_q;
        addr_d = addr_q;
        timer_d = timer_q;
        idx_d = idx_q;
        clr = 1'b0;
        if (byte_ev && state_q != eeprom_pkg::ST_PROG)
        begin
            case (rx_kind)
                eeprom_pkg::KIND_AHI: addr_d[15:8] = rx_byte;
                eeprom_pkg::KIND_ALO: addr_d[7:0] = rx_byte;
                eeprom_pkg::KIND_DATA: addr_d[6:0] = addr_q[6:0] + 7'h01;
                default: addr_d = addr_q;
            endcase
        end
        case (state_q)
            eeprom_pkg::ST_IDLE:
            begin
                if (wr_hit)
                begin
                    state_d = eeprom_pkg::ST_RECV;
                end
            end
            eeprom_pkg::ST_RECV:
            begin
                if (stop_ev && wp_s)
                begin
                    state_d = eeprom_pkg::ST_IDLE;
                    clr = 1'b1;
                end
                else if (stop_ev)
                begin
                    state_d = eeprom_pkg::ST_PROG;
                    timer_d = 17'h00000;
                    idx_d = 8'h00;
                end
            end
            eeprom_pkg::ST_PROG:
            begin
                timer_d = timer_q + 17'h00001;
                if (idx_q != eeprom_pkg::PAGE_BYTES)
                begin
                    idx_d = idx_q + 8'h01;
                end
                if (timer_q == WR_LAST)
                begin
                    state_d = eeprom_pkg::ST_IDLE;
                    clr = 1'b1;
                end
            end
            default:
            begin
                state_d = eeprom_pkg::ST_IDLE;
                clr = 1'b1;
            end
        endcase
        // Only buffered bytes are written; unsent bytes of the page keep
        // their old contents in the array.
        we_d = state_q == eeprom_pkg::ST_PROG && idx_q != eeprom_pkg::PAGE_BYTES
            && vld_q[idx_q[6:0]] && !wp_s;
        maddr_d = {addr_q[15:7], idx_q[6:0]};
        mdata_d = pbuf_q[idx_q[6:0]];
        if (!nrst)
        begin
            state_d = eeprom_pkg::ST_IDLE;
            addr_d = 16'h0000;
            timer_d = 17'h00000;
            idx_d = 8'h00;
            clr = 1'b1;
            we_d = 1'b0;
            maddr_d = 16'h0000;
            mdata_d = 8'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        state_q <= state_d;
        addr_q <= addr_d;
        timer_q <= timer_d;
        idx_q <= idx_d;
        we_q <= we_d;
        maddr_q <= maddr_d;
        mdata_q <= mdata_d;
    end

    // ************************************************************
    // Page buffer
    // ************************************************************
    for (genvar i = 0; i < eeprom_pkg::PAGE_N; i++)
    begin : g_ent
        logic hit;
        logic vld_d;
        logic [7:0] dat_d;

        always_comb
        begin
            hit = wr_hit && addr_q[6:0] == 7'(i);
            vld_d = vld_q[i];
            dat_d = pbuf_q[i];
            if (clr)
            begin
                vld_d = 1'b0;
            end
            // A byte landing in the clearing cycle is kept.
            if (hit)
            begin
                vld_d = 1'b1;
                dat_d = rx_byte;
            end
        end

        always_ff @(posedge core_clk)
        begin
            vld_q[i] <= vld_d;
            pbuf_q[i] <= dat_d;
        end
    end

    assign write_busy = state_q == eeprom_pkg::ST_PROG;
    assign standby = idle_q && state_q != eeprom_pkg::ST_PROG;
    assign word_addr = addr_q;
    assign mem_we = we_q;
    assign mem_addr = maddr_q;
    assign mem_wdata = mdata_q;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_start_wake;
        @(posedge core_clk) disable iff (!nrst)
        start_ev |=> !idle_q && !standby;
    endproperty
    a_start_wake: assert property (p_start_wake) else $error("start not taken");

    property p_stop_rest;
        @(posedge core_clk) disable iff (!nrst)
        (stop_ev && state_q == eeprom_pkg::ST_IDLE) |=> standby;
    endproperty
    a_stop_rest: assert property (p_stop_rest) else $error("no standby after stop");

    property p_prog_start;
        @(posedge core_clk) disable iff (!nrst)
        (state_q == eeprom_pkg::ST_RECV && stop_ev && !wp_s)
            |=> write_busy && timer_q == 17'h00000 && !standby;
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("write not started");

    property p_prog_end;
        @(posedge core_clk) disable iff (!nrst)
        (write_busy && timer_q == WR_LAST) |=> !write_busy && vld_q == '0;
    endproperty
    a_prog_end: assert property (p_prog_end) else $error("write time wrong");

    property p_wp_drop;
        @(posedge core_clk) disable iff (!nrst)
        (state_q == eeprom_pkg::ST_RECV && stop_ev && wp_s)
            |=> state_q == eeprom_pkg::ST_IDLE ##1 !mem_we;
    endproperty
    a_wp_drop: assert property (p_wp_drop) else $error("protected write ran");

    property p_wp_gate;
        @(posedge core_clk) disable iff (!nrst)
        wp_s |=> !mem_we;
    endproperty
    a_wp_gate: assert property (p_wp_gate) else $error("array written under protect");

    property p_wrap;
        @(posedge core_clk) disable iff (!nrst)
        wr_hit |=> addr_q[15:7] == $past(addr_q[15:7])
            && addr_q[6:0] == $past(addr_q[6:0]) + 7'h01;
    endproperty
    a_wrap: assert property (p_wrap) else $error("address left the page");

    property p_page;
        @(posedge core_clk) disable iff (!nrst)
        mem_we |-> write_busy && mem_addr[15:7] == addr_q[15:7];
    endproperty
    a_page: assert property (p_page) else $error("write outside page");

    c_byte_write: cover property (@(posedge core_clk) disable iff (!nrst)
        state_q == eeprom_pkg::ST_RECV ##1 write_busy);
    c_page_wrap: cover property (@(posedge core_clk) disable iff (!nrst)
        wr_hit && addr_q[6:0] == 7'h7F);
    c_wp_drop: cover property (@(posedge core_clk) disable iff (!nrst)
        state_q == eeprom_pkg::ST_RECV && stop_ev && wp_s);
    c_prog_done: cover property (@(posedge core_clk) disable iff (!nrst)
        write_busy ##1 !write_busy);

endmodule

`default_nettype wire

// ---- bench/i2c_ctrl_model.sv ----
/* Behavioural two-wire bus controller: drives the serial clock and data.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module i2c_ctrl_model (
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    // ************************************************************
    // Bus primitives
    // ************************************************************
    // The clock stands high between frames, as a real controller leaves it.
    initial
    begin
        scl = 1'h1;
        sda_rel = 1'h1;
    end
    task automatic bus_start();
        sda_rel = 1'h1;
        #40 scl = 1'h1;
        #80 sda_rel = 1'h0;
        #80 scl = 1'h0;
        #40;
    endtask
    task automatic put_bit(input logic b);
        sda_rel = b;
        #40 scl = 1'h1;
        #80 scl = 1'h0;
        #40;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(b[i]);
        sda_rel = 1'h1;
        #40 scl = 1'h1;
        #40 ack = ~sda_line;
        #40 scl = 1'h0;
        #40;
    endtask
    task automatic bus_stop();
        sda_rel = 1'h0;
        #40 scl = 1'h1;
        #80 sda_rel = 1'h1;
        #400;
    endtask
    task automatic recover();
        bus_start();
        repeat (9) put_bit(1'h1);
        bus_start();
        bus_stop();
    endtask
    task automatic idle_clocks(input int n);
        repeat (n)
        begin
            #80 scl = 1'h0;
            #80 scl = 1'h1;
        end
    endtask
endmodule
`default_nettype wire

// ---- bench/serial_eeprom_write_path_bench.sv ----
/* Self-checking bench of the EEPROM write path against a model controller.
   Assumes the design carries its own assertions. */
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_write_path_bench;
    localparam int WR_N = 300;
    // Device-type pattern; the value is arbitrary.
    localparam logic [3:0] DEV = 4'h5;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic wp = 1'h0;
    logic [2:0] sel = 3'h5;
    logic scl, sda_rel, sda_line, sda_out, sda_oe, write_busy, standby, mem_we, ack;
    logic [15:0] word_addr, mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem [logic [15:0]];
    int miscompares = 0;
    int check_count = 0;
    int we_n = 0;
    int busy_len = 0;
    always #25 core_clk = ~core_clk;
    // Open-drain data line with its pull-up.
    assign sda_line = (sda_oe ? sda_out : 1'h1) & sda_rel;
    eeprom_write_path #(.DEV_TYPE(DEV), .WR_CYCLES(WR_N)) i_eeprom_write_path (
        .core_clk(core_clk), .nrst(nrst), .serial_clk(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .device_select_bit2(sel[2]),
        .device_select_bit1(sel[1]), .device_select_bit0(sel[0]),
        .write_protect(wp), .write_busy(write_busy), .standby(standby),
        .word_addr(word_addr), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata)
    );
    i2c_ctrl_model i_i2c_ctrl_model (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
    // ************************************************************
    // Array port monitor and scenarios
    // ************************************************************
    always @(posedge core_clk)
    begin
        if (mem_we === 1'h1)
        begin
            mem[mem_addr] = mem_wdata;
            we_n++;
        end
        if (write_busy === 1'h1)
            busy_len++;
        if (sda_oe === 1'h1)
            check("sda_out", sda_out, 1'h0);
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic addr_frame(input logic [7:0] a, input logic exp);
        i_i2c_ctrl_model.bus_start();
        i_i2c_ctrl_model.send_byte(a, ack);
        check("addr_ack", ack, exp);
        i_i2c_ctrl_model.bus_stop();
    endtask
    task automatic write_frame(input logic [15:0] a, input int n, input logic [7:0] d0);
        we_n = 0;
        busy_len = 0;
        mem.delete();
        i_i2c_ctrl_model.bus_start();
        i_i2c_ctrl_model.send_byte({DEV, sel, 1'h0}, ack);
        check("wr_ack", ack, 1'h1);
        i_i2c_ctrl_model.send_byte(a[15:8], ack);
        check("hi_ack", ack, 1'h1);
        i_i2c_ctrl_model.send_byte(a[7:0], ack);
        check("lo_ack", ack, 1'h1);
        for (int i = 0; i < n; i++)
        begin
            i_i2c_ctrl_model.send_byte(d0 + 8'(i), ack);
            check("data_ack", ack, 1'h1);
        end
        i_i2c_ctrl_model.bus_stop();
        ticks(20);
    endtask
    task automatic wait_done();
        for (int i = 0; i < 2 * WR_N && write_busy !== 1'h0; i++)
            @(posedge core_clk);
        ticks(2);
        check("wr_done", write_busy, 1'h0);
    endtask
    task automatic t_byte_write();
        write_frame(16'h1234, 1, 8'hA5);
        check("busy", write_busy, 1'h1);
        check("standby_busy", standby, 1'h0);
        addr_frame({DEV, sel, 1'h1}, 1'h0);
        wait_done();
        check("busy_len", busy_len, WR_N);
        check("we_n", we_n, 1);
        check("mem", mem[16'h1234], 8'hA5);
        check("standby", standby, 1'h1);
        addr_frame({DEV, sel, 1'h1}, 1'h1);
    endtask
    task automatic t_select();
        for (int s = 0; s < 8; s++)
            addr_frame({DEV, 3'(s), 1'h1}, 3'(s) == sel);
        addr_frame({DEV ^ 4'h1, sel, 1'h1}, 1'h0);
        ticks(10);
        check("standby_rd", standby, 1'h1);
        check("no_write", write_busy, 1'h0);
    endtask
    task automatic t_protect();
        ticks(1);
        wp = 1'h1;
        write_frame(16'h0010, 1, 8'h5A);
        check("wp_busy", write_busy, 1'h0);
        check("wp_we", we_n, 0);
        wp = 1'h0;
        // The last page slot is programmed late, after protect is raised again.
        write_frame(16'h007F, 1, 8'h3C);
        wp = 1'h1;
        wait_done();
        check("wp_gate", we_n, 0);
        wp = 1'h0;
    endtask
    task automatic t_page();
        write_frame(16'h047E, 130, 8'h00);
        wait_done();
        check("page_we", we_n, 128);
        check("wrap_a", mem[16'h047E], 8'h80);
        check("wrap_b", mem[16'h047F], 8'h81);
        check("page_start", mem[16'h0400], 8'h02);
        check("no_spill", mem.exists(16'h0480), 1'h0);
        check("word_addr", word_addr, 16'h0400);
    endtask
    task automatic t_recover();
        i_i2c_ctrl_model.bus_start();
        repeat (4) i_i2c_ctrl_model.put_bit(1'h1);
        i_i2c_ctrl_model.recover();
        addr_frame({DEV, sel, 1'h1}, 1'h1);
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Reset spans serial clocks, and a few follow its release, because the link
    // domain only sees the release through serial clock edges.
    initial
    begin
        i_i2c_ctrl_model.idle_clocks(5);
        @(posedge core_clk);
        #1 nrst = 1'h1;
        i_i2c_ctrl_model.idle_clocks(3);
        ticks(4);
        check("standby_rst", standby, 1'h1);
        check("oe_rst", sda_oe, 1'h0);
        t_byte_write();
        t_select();
        t_protect();
        t_page();
        t_recover();
        print_verdict();
    end
    // The full-page write dominates at about 0.2 ms of a run near 0.3 ms; allow some three times the run.
    initial
    begin
        #1_000_000;
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
